// *** rtl/bss_regs.svh ***
// timing and field constants for the buck start-up sequencer
// assumes a 40 MHz core clock; included by bare name
`ifndef BSS_REGS_SVH
`define BSS_REGS_SVH
`define BSS_CLK_MHZ 40
`define BSS_INIT_DELAY_US 6800
`define BSS_INIT_DELAY_CYC (`BSS_INIT_DELAY_US * `BSS_CLK_MHZ)
`define BSS_SAMPLE_MAX_US 3400
`define BSS_SAMPLE_MAX_CYC (`BSS_SAMPLE_MAX_US * `BSS_CLK_MHZ)
`define BSS_SS_US 6800
`define BSS_SS_CYC (`BSS_SS_US * `BSS_CLK_MHZ)
`define BSS_SS_STEPS 64
`define BSS_DUMMY_RUNS 2
`define BSS_OC_W 8
`define BSS_REF_W 7
`define BSS_CNT_W 20
// top bit of the sample-tick field: one trip step per 4096 cycles
`define BSS_OC_TICK_MSB 11
`define BSS_OC_MAX 8'hFF
`endif

// *** rtl/bss_pkg.sv ***
// types for the buck start-up sequencer
// assumes bss_regs.svh for widths
`include "bss_regs.svh"
package bss_pkg;
  typedef enum logic [2:0] {
    BSS_WAIT_EN,
    BSS_DELAY,
    BSS_SAMPLE,
    BSS_SOFT,
    BSS_RUN,
    BSS_RETRY
  } bss_state_t;
  typedef logic [`BSS_OC_W-1:0] bss_oc_t;
  typedef logic [`BSS_REF_W-1:0] bss_ref_t;
endpackage : bss_pkg

// *** rtl/bss_sync.sv ***
// two flip-flop synchroniser for a vector of pin levels
// assumes inputs are asynchronous to clk
`timescale 1ns/100ps
module bss_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] meta_q;
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      meta_q <= '0;
      dout <= '0;
    end
    else
    begin
      meta_q <= din;
      dout <= meta_q;
    end
  end
endmodule : bss_sync

// *** rtl/bss_gate_interlock.sv ***
// adaptive dead-time interlock between the two gate drivers
// assumes synchronised monitor levels from the power stage
`timescale 1ns/100ps
module bss_gate_interlock (
  input wire logic clk,
  input wire logic rst,
  input wire logic enable,
  input wire logic pwm_high,
  input wire logic high_off_seen,
  input wire logic low_off_seen,
  output logic high_gate_q,
  output logic low_gate_q
);
  // each side turns on only after the other is seen off
  always_ff @(posedge clk)
  begin
    if (rst || !enable)
    begin
      high_gate_q <= 1'b0;
      low_gate_q <= 1'b0;
    end
    else
    begin
      high_gate_q <= pwm_high && !low_gate_q && low_off_seen;
      low_gate_q <= !pwm_high && !high_gate_q && high_off_seen;
    end
  end
endmodule : bss_gate_interlock

// *** rtl/bss_sequencer.sv ***
// start-up, shutdown and hiccup sequencer for a synchronous buck controller
// assumes comparator levels arrive asynchronously from analog blocks;
// rst is the power-on reset, asserted while bias is below reset_threshold
`timescale 1ns/100ps
`include "bss_regs.svh"

// How it works
// - shutdown stops oscillator, gates low, re-arms
// - enable release starts full new initialization
// - bias above threshold starts init delay
// - enable low at power-up postpones initialization
// - timing starts at threshold crossing or enable release
// - fixed delay before sampling trip setting
// - delay: low gate off, trip current on
// - sample length grows with setting
// - held trip setting in counter, no decay
// - sample done starts soft-start at once
// - trip: two dummy time-outs, then retry
// - low side waits for high off
// - high side waits for low off
// - soft-start ramp in 64 equal steps
// - no resample during hiccup retries
module bss_sequencer #(
  parameter int INIT_DELAY_CYC = `BSS_INIT_DELAY_CYC,
  parameter int SAMPLE_MAX_CYC = `BSS_SAMPLE_MAX_CYC,
  parameter int SS_CYC = `BSS_SS_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic enable_shutdown_pin,
  input wire logic trip_set_above,
  input wire logic overcurrent_protection,
  input wire logic pwm_high,
  input wire logic high_off_seen,
  input wire logic low_off_seen,
  output logic high_side_gate,
  output logic low_side_gate,
  output logic osc_run_q,
  output logic trip_set_current_q,
  output logic amp_enable_q,
  output bss_pkg::bss_oc_t trip_level_q,
  output bss_pkg::bss_ref_t soft_ref_q,
  output bss_pkg::bss_state_t state_q
);
  import bss_pkg::*;

  // ==========================================================
  // input synchronisers
  // ==========================================================
  logic [4:0] sync_out;
  logic en_s;
  logic trip_above_s;
  logic oc_s;
  logic hoff_s;
  logic loff_s;

  bss_sync #(.W(5)) u_sync (
    .clk(clk),
    .rst(rst),
    .din({enable_shutdown_pin, trip_set_above, overcurrent_protection,
          high_off_seen, low_off_seen}),
    .dout(sync_out)
  );
  assign en_s = sync_out[4];
  assign trip_above_s = sync_out[3];
  assign oc_s = sync_out[2];
  assign hoff_s = sync_out[1];
  assign loff_s = sync_out[0];

  // ==========================================================
  // sequence state machine
  // ==========================================================
  bss_state_t state_d;
  logic [`BSS_CNT_W-1:0] cnt_q;
  logic [`BSS_CNT_W-1:0] step_len;
  logic [1:0] dummy_q;
  logic [`BSS_OC_W:0] oc_step_q;
  logic cnt_done;
  logic sample_done;
  logic ss_done;
  logic step_tick;

  assign step_len = `BSS_CNT_W'(SS_CYC / `BSS_SS_STEPS);
  assign cnt_done = (cnt_q == `BSS_CNT_W'(INIT_DELAY_CYC - 1));
  // sample period stretches linearly with the setting up to the max
  assign sample_done = !trip_above_s || (trip_level_q == `BSS_OC_MAX) ||
                       (cnt_q == `BSS_CNT_W'(SAMPLE_MAX_CYC - 1));
  assign step_tick = (cnt_q == step_len - `BSS_CNT_W'(1));
  assign ss_done = step_tick && (oc_step_q == (`BSS_OC_W+1)'(`BSS_SS_STEPS - 1));

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      BSS_WAIT_EN:
      begin
        // start on the synchronised enable level, not on an edge of it
        if (en_s)
        begin
          state_d = BSS_DELAY;
        end
      end
      BSS_DELAY:
      begin
        if (cnt_done)
        begin
          state_d = BSS_SAMPLE;
        end
      end
      BSS_SAMPLE:
      begin
        if (sample_done)
        begin
          state_d = BSS_SOFT;
        end
      end
      BSS_SOFT:
      begin
        // a trip during the ramp is treated like one in regulation
        if (oc_s)
        begin
          state_d = BSS_RETRY;
        end
        else if (ss_done)
        begin
          state_d = BSS_RUN;
        end
      end
      BSS_RUN:
      begin
        if (oc_s)
        begin
          state_d = BSS_RETRY;
        end
      end
      BSS_RETRY:
      begin
        // held trip level is reused; no return through sampling
        if (ss_done && dummy_q == 2'(`BSS_DUMMY_RUNS - 1))
        begin
          state_d = BSS_SOFT;
        end
      end
      default:
      begin
        state_d = BSS_WAIT_EN;
      end
    endcase
    // shutdown overrides every state, so a cut sequence always re-arms
    if (!en_s)
    begin
      state_d = BSS_WAIT_EN;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_q <= BSS_WAIT_EN;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  // ==========================================================
  // oscillator-clocked counters
  // ==========================================================
  // cleared on every state change so each phase times from zero
  always_ff @(posedge clk)
  begin
    if (rst || state_d != state_q)
    begin
      cnt_q <= '0;
    end
    else if ((state_q == BSS_SOFT || state_q == BSS_RETRY) && step_tick)
    begin
      cnt_q <= '0;
    end
    else if (state_q != BSS_WAIT_EN && state_q != BSS_RUN)
    begin
      cnt_q <= cnt_q + `BSS_CNT_W'(1);
    end
  end

  // ramp step counter, shared by real and dummy soft-start periods
  always_ff @(posedge clk)
  begin
    if (rst || state_d != state_q)
    begin
      oc_step_q <= '0;
    end
    else if ((state_q == BSS_SOFT || state_q == BSS_RETRY) && step_tick)
    begin
      if (ss_done)
      begin
        oc_step_q <= '0;
      end
      else
      begin
        oc_step_q <= oc_step_q + (`BSS_OC_W+1)'(1);
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst || state_q != BSS_RETRY)
    begin
      dummy_q <= '0;
    end
    else if (ss_done)
    begin
      dummy_q <= dummy_q + 2'(1);
    end
  end

  // ==========================================================
  // trip level sample and hold
  // ==========================================================
  // counter advances while the set voltage stays above the dac level
  // limitation: one step per sample tick, so a short phase holds zero
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      trip_level_q <= '0;
    end
    else if (state_q == BSS_DELAY)
    begin
      trip_level_q <= '0;
    end
    else if (state_q == BSS_SAMPLE && !sample_done &&
             cnt_q[`BSS_OC_TICK_MSB:0] == '1)
    begin
      trip_level_q <= trip_level_q + `BSS_OC_W'(1);
    end
  end

  // ==========================================================
  // soft-start reference ramp
  // ==========================================================
  always_ff @(posedge clk)
  begin
    if (rst || (state_q != BSS_SOFT && state_q != BSS_RUN))
    begin
      soft_ref_q <= '0;
    end
    else if (state_q == BSS_RUN)
    begin
      soft_ref_q <= `BSS_REF_W'(`BSS_SS_STEPS);
    end
    else if (step_tick)
    begin
      soft_ref_q <= `BSS_REF_W'(oc_step_q) + `BSS_REF_W'(1);
    end
  end

  // ==========================================================
  // output controls
  // ==========================================================
  // decoded from the next state so the pins move with the state register
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      osc_run_q <= 1'b0;
    end
    else
    begin
      osc_run_q <= (state_d == BSS_SOFT || state_d == BSS_RUN);
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      trip_set_current_q <= 1'b0;
    end
    else
    begin
      trip_set_current_q <= (state_d == BSS_DELAY || state_d == BSS_SAMPLE);
    end
  end

  // amplifier drops with the pin so the pull-down fights it only briefly
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      amp_enable_q <= 1'b0;
    end
    else
    begin
      amp_enable_q <= en_s;
    end
  end

  // gates only switch while the oscillator runs; held low during delay
  bss_gate_interlock u_gates (
    .clk(clk),
    .rst(rst),
    .enable(osc_run_q),
    .pwm_high(pwm_high),
    .high_off_seen(hoff_s),
    .low_off_seen(loff_s),
    .high_gate_q(high_side_gate),
    .low_gate_q(low_side_gate)
  );
endmodule : bss_sequencer

// *** tb/bss_stage_model.sv ***
// external power stage: gate turn-off seen one cycle late
// assumes gate levels from the sequencer
`timescale 1ns/100ps
module bss_stage_model (
  input wire logic clk,
  input wire logic high_side_gate,
  input wire logic low_side_gate,
  output logic high_off_seen,
  output logic low_off_seen
);
  // lag forces the interlock to wait
  always_ff @(posedge clk)
  begin
    high_off_seen <= !high_side_gate;
    low_off_seen <= !low_side_gate;
  end
endmodule : bss_stage_model

// *** tb/bss_seq_monitor.sv ***
// port checks for the sequencer
// assumes bind from tb
`timescale 1ns/100ps
module bss_seq_monitor
  import bss_pkg::*;
#(
  parameter int INIT_DELAY_CYC = 64
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic enable_shutdown_pin,
  input wire logic trip_set_above,
  input wire logic overcurrent_protection,
  input wire logic pwm_high,
  input wire logic high_off_seen,
  input wire logic low_off_seen,
  input wire logic high_side_gate,
  input wire logic low_side_gate,
  input wire logic osc_run_q,
  input wire logic trip_set_current_q,
  input wire logic amp_enable_q,
  input wire bss_pkg::bss_oc_t trip_level_q,
  input wire bss_pkg::bss_ref_t soft_ref_q,
  input wire bss_pkg::bss_state_t state_q
);
  localparam int DL = INIT_DELAY_CYC - 2;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  // ====
  // checks
  property p_hi; $rose(high_side_gate) |-> $past(!low_side_gate); endproperty
  a_hi: assert property (p_hi) else $error("high gate overlap");
  property p_lo; $rose(low_side_gate) |-> $past(!high_side_gate); endproperty
  a_lo: assert property (p_lo) else $error("low gate overlap");
  property p_sd; !enable_shutdown_pin [*5] |-> state_q == BSS_WAIT_EN; endproperty
  a_sd: assert property (p_sd) else $error("no shutdown");
  property p_off;
    !osc_run_q && $past(!osc_run_q) |-> !high_side_gate && !low_side_gate;
  endproperty
  a_off: assert property (p_off) else $error("gate while stopped");
  property p_dl;
    state_q == BSS_DELAY && $past(state_q) == BSS_DELAY |->
      trip_set_current_q && !low_side_gate;
  endproperty
  a_dl: assert property (p_dl) else $error("delay drive");
  property p_len;
    $rose(state_q == BSS_DELAY) |-> ##DL state_q == BSS_DELAY ##[1:2] state_q == BSS_SAMPLE;
  endproperty
  a_len: assert property (p_len) else $error("delay length");
  property p_rt;
    $past(state_q) == BSS_RETRY && state_q != BSS_RETRY |->
      state_q inside {BSS_SOFT, BSS_WAIT_EN};
  endproperty
  a_rt: assert property (p_rt) else $error("retry exit");
  property p_run; state_q == BSS_RUN |-> soft_ref_q == 7'h40; endproperty
  a_run: assert property (p_run) else $error("run ref");
endmodule : bss_seq_monitor

// *** tb/tb.sv ***
// self-checking bench for the start-up sequencer
// assumes stage model and monitor compiled first
`timescale 1ns/100ps
module tb;
  import bss_pkg::*;
  logic clk, rst, en, ta, oc, pwm, hg, lg, hof, lof, osc, tsc, amp;
  bss_oc_t lvl, lv0;
  bss_ref_t sref;
  bss_state_t st;
  int mismatches, total_checks, n;
  // long sample cap so the held trip level climbs to 2 while the set input stays high
  bss_sequencer #(.INIT_DELAY_CYC(64), .SAMPLE_MAX_CYC(9000), .SS_CYC(640)) DUT (
    .clk(clk), .rst(rst), .enable_shutdown_pin(en), .trip_set_above(ta),
    .overcurrent_protection(oc), .pwm_high(pwm), .high_off_seen(hof), .low_off_seen(lof),
    .high_side_gate(hg), .low_side_gate(lg), .osc_run_q(osc), .trip_set_current_q(tsc),
    .amp_enable_q(amp), .trip_level_q(lvl), .soft_ref_q(sref), .state_q(st));
  bss_stage_model stage (.clk(clk), .high_side_gate(hg), .low_side_gate(lg),
    .high_off_seen(hof), .low_off_seen(lof));
  initial
  begin
    clk = 0;
    forever #12.5 clk = ~clk;
  end
  task close_out;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : close_out
  task chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task tick(input int k);
    repeat (k) @(posedge clk);
    #2;
  endtask : tick
  // bounded wait; n returns cycles spent
  task wait_st(input bss_state_t s);
    n = 0;
    while (st !== s && n < 12000)
    begin
      tick(1);
      n++;
    end
    if (st !== s)
    begin
      mismatches++;
      close_out();
    end
  endtask : wait_st
  task t_powerup;
    tick(20);
    chk("held", st, BSS_WAIT_EN);
    en = 1;
    wait_st(BSS_DELAY);
    tick(2);
    chk("delay drive", {tsc, lg}, 8'h02);
    wait_st(BSS_SAMPLE);
    chk("delay", n >= 58 && n <= 66, 8'h01);
    wait_st(BSS_SOFT);
    chk("long sample", n >= 8990 && n <= 9010, 8'h01);
    chk("level", lvl, 8'h02);
    wait_st(BSS_RUN);
    chk("ramp", n >= 630 && n <= 650, 8'h01);
    chk("run", {sref, osc}, 8'h81);
  endtask : t_powerup
  task t_gates;
    pwm = 1;
    tick(8);
    chk("high on", {hg, lg}, 8'h02);
    pwm = 0;
    tick(8);
    chk("low on", {hg, lg}, 8'h01);
  endtask : t_gates
  task t_hiccup;
    lv0 = lvl;
    oc = 1;
    wait_st(BSS_RETRY);
    oc = 0;
    tick(4);
    chk("retry osc", osc, 8'h00);
    wait_st(BSS_SOFT);
    chk("dummy runs", n >= 1270 && n <= 1285, 8'h01);
    chk("level", lvl, lv0);
    // ten cycles per step with these parameters
    tick(100);
    chk("ramp step", sref, 8'h0A);
    wait_st(BSS_RUN);
  endtask : t_hiccup
  task t_shutdown;
    pwm = 1;
    ta = 0;
    en = 0;
    wait_st(BSS_WAIT_EN);
    tick(3);
    chk("off", {osc, hg, lg, amp}, 8'h00);
    en = 1;
    wait_st(BSS_DELAY);
    tick(2);
    chk("resample", lvl, 8'h00);
    wait_st(BSS_SOFT);
    chk("short sample", n >= 58 && n <= 72, 8'h01);
  endtask : t_shutdown
  // power-on reset on entry to soft-start with the pin already released
  task t_por;
    rst = 1;
    tick(2);
    chk("por hold", {st, osc, tsc, amp, hg, lg}, 8'h00);
    tick(6);
    rst = 0;
    wait_st(BSS_DELAY);
    chk("por start", n >= 2 && n <= 4, 8'h01);
    tick(2);
    chk("por drive", {tsc, lg}, 8'h02);
  endtask : t_por
  initial
  begin
    rst = 1;
    en = 0;
    ta = 1;
    oc = 0;
    pwm = 0;
    mismatches = 0;
    total_checks = 0;
    tick(8);
    rst = 0;
    t_powerup();
    t_gates();
    t_hiccup();
    t_gates();
    t_shutdown();
    t_por();
    close_out();
  end
endmodule : tb
bind bss_sequencer bss_seq_monitor #(.INIT_DELAY_CYC(INIT_DELAY_CYC)) mon (
  .clk(clk), .rst(rst), .enable_shutdown_pin(enable_shutdown_pin),
  .trip_set_above(trip_set_above), .overcurrent_protection(overcurrent_protection),
  .pwm_high(pwm_high), .high_off_seen(high_off_seen), .low_off_seen(low_off_seen),
  .high_side_gate(high_side_gate), .low_side_gate(low_side_gate), .osc_run_q(osc_run_q),
  .trip_set_current_q(trip_set_current_q), .amp_enable_q(amp_enable_q),
  .trip_level_q(trip_level_q), .soft_ref_q(soft_ref_q), .state_q(state_q));
